// file: chc_card_model.sv
// card side of the link: serial clock, reply bits on CMD, DAT0 busy, wp
// assumes the bench calls send for each reply and drives busy and wp
`timescale 1ns/10ps
`default_nettype none
module chc_card_model (
	input  wire logic busy,
	input  wire logic wp,
	output logic      card_sclk,
	output logic      card_cmd,
	output logic      card_dat0,
	output logic      card_wp
);
	// released lines go to their pull-up level
	assign card_dat0 = busy ? 1'b0 : 1'b1;
	assign card_wp   = wp;

	initial begin
		card_sclk = 1'b0;
		card_cmd  = 1'b1;
	end

	// reply bits first bit first, one per 160 ns clock, clock still after
	task automatic send(input logic [135:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			card_cmd = v[i];
			#40 card_sclk = 1'b1;
			#80 card_sclk = 1'b0;
			#40;
		end
		card_cmd = 1'b1;
	endtask
endmodule
`default_nettype wire

// file: chc_pkg.sv
// constants, register map and carrier types of the card host status block
// assumes a 32-bit register port with byte addresses and one system clock
`default_nettype none
package chc_pkg;
	// register byte offsets
	localparam logic [7:0] CHC_ADDR_CMD_PARAM  = 8'h28;
	localparam logic [7:0] CHC_ADDR_HOST_COND  = 8'h2C;
	localparam logic [7:0] CHC_ADDR_REPLY_0    = 8'h30;
	localparam logic [7:0] CHC_ADDR_REPLY_1    = 8'h34;
	localparam logic [7:0] CHC_ADDR_REPLY_2    = 8'h38;
	localparam logic [7:0] CHC_ADDR_REPLY_3    = 8'h3C;
	localparam logic [7:0] CHC_ADDR_CMD_EVENT  = 8'h40;
	localparam logic [7:0] CHC_ADDR_XFER_EVENT = 8'h44;
	localparam logic [7:0] CHC_ADDR_CARD_COND  = 8'h48;
	localparam logic [7:0] CHC_ADDR_SUPPRESS_0 = 8'h4C;
	localparam logic [7:0] CHC_ADDR_SUPPRESS_1 = 8'h50;

	// host condition bit positions
	localparam int CHC_HC_HOST_ACTIVE = 0;
	localparam int CHC_HC_CMD_ACTIVE  = 1;
	localparam int CHC_HC_DAT_ACTIVE  = 2;
	localparam int CHC_HC_BUSY_DAT0   = 4;
	localparam int CHC_HC_WRITE_PROT  = 15;

	// command event bit positions
	localparam int CHC_CE_CMD_DONE    = 0;
	localparam int CHC_CE_CMD_TIMEOUT = 1;
	localparam int CHC_CE_RESP_CRC    = 2;
	localparam int CHC_CE_CARD_INT    = 3;

	// transfer event bit positions
	localparam int CHC_XE_BLOCK_DONE   = 0;
	localparam int CHC_XE_DATA_TIMEOUT = 1;
	localparam int CHC_XE_DATA_CRC     = 2;

	// card condition bits that exist; the rest read as zero
	localparam logic [31:0] CHC_CARD_COND_VALID = 32'hFDFF_0008;

	// reply kind codes
	localparam logic [2:0] CHC_REPLY_NONE = 3'h0;
	localparam logic [2:0] CHC_REPLY_R1   = 3'h1;
	localparam logic [2:0] CHC_REPLY_R2   = 3'h2;
	localparam logic [2:0] CHC_REPLY_R1B  = 3'h7;

	// token bit windows
	localparam int CHC_TOKEN_BITS = 136;
	localparam int CHC_SHORT_LO   = 8;
	localparam int CHC_SHORT_HI   = 39;

	// signals from the command and data engines, same clock
	typedef struct packed {
		logic       cmd_line_busy;
		logic       dat_xfer_busy;
		logic       dat_engaged;
		logic       r1b_watch;
		logic       resp_window;
		logic       resp_store;
		logic [2:0] reply_kind;
		logic [3:0] cmd_ev;
		logic [2:0] xfer_ev;
	} chc_eng_s;

	typedef struct packed {
		logic [31:0]                 cmd_param;
		logic [127:0]                reply;
		logic [3:0]                  cmd_event;
		logic [2:0]                  xfer_event;
		logic [31:0]                 card_cond;
		logic [63:0]                 suppress;
		logic [CHC_TOKEN_BITS-1:0]   token;
		logic                        sclk_prev;
		logic [31:0]                 rdata;
		logic                        irq;
	} chc_state_s;

	localparam chc_state_s CHC_STATE_RST = '0;
endpackage
`default_nettype wire

// file: chc_status_regs.sv
// argument, status, reply and event registers of the card host controller
// assumes engines on sys_clk drive eng; card pins and sclk are asynchronous
//
// Overview of operation
// - a 32-bit read/write register holds the next command argument
// - host_active reads 1 while CMD or DAT lines are in use
// - cmd_line_active reads 1 while the CMD line is transferring
// - dat_line_active reads 1 while a data transfer runs on DAT
// - card_busy_dat0 reads 1 while DAT0 signals busy after an R1b command
// - bit 15 of host condition shows the write-protect switch, 1 protected
// - R2 stores token bits 127..0; other replies store bits 39..8 in word 0
// - reply words hold the last reply until the next one arrives
// - reading an event or card condition register clears it and its interrupt
// - command and transfer event bits are interrupt sources
// - cmd_done sets on completion without reply or reply without CRC error
// - cmd_timeout sets when no reply arrives in time
// - resp_crc_err sets when a reply fails its CRC check
// - card_int_request, bit 3, sets on a class 9 card interrupt request
// - block_finished sets after each good data block
// - data_timeout sets when a data token does not arrive in time
// - data_crc_err sets on a bad read block or card-reported write CRC error
// - after R1 or R1b replies the card status loads the card condition register
// - each card condition bit reads 1 for error, 0 for none
// - a 64-bit mask gates sources; a 1 suppresses the matching bit
// - reply kind code 010 expects a 136-bit token filling all four words
`timescale 1ns/10ps
`default_nettype none
module chc_status_regs #(
	parameter int ADDR_W = 8
) (
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	input  wire logic              card_sclk,
	input  wire logic              card_cmd,
	input  wire logic              card_dat0,
	input  wire logic              card_wp,
	input  wire chc_pkg::chc_eng_s eng,
	output logic                   card_irq
);
	chc_pkg::chc_state_s st;
	chc_pkg::chc_state_s next_st;

	logic [3:0]   pin_sync;
	logic         sclk_s;
	logic         cmd_s;
	logic         dat0_s;
	logic         wp_s;
	logic         sclk_rise;
	logic         host_active;
	logic         card_busy_dat0;
	logic [15:0]  host_cond;
	logic [7:0]   addr8;
	logic         rd_cmd_ev;
	logic         rd_xfer_ev;
	logic         rd_card_cond;
	logic [31:0]  card_load;
	logic         card_load_en;
	logic [127:0] token_lo;
	logic [31:0]  token_short;

	// card side pins pass two flops before any use
	chc_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.rstn   (rstn),
		.ce     (ce),
		.din    ({card_wp, card_dat0, card_cmd, card_sclk}),
		.dout   (pin_sync)
	);

	assign sclk_s = pin_sync[0];
	assign cmd_s  = pin_sync[1];
	assign dat0_s = pin_sync[2];
	assign wp_s   = pin_sync[3];

	assign addr8       = 8'(reg_addr);
	assign sclk_rise   = sclk_s & ~st.sclk_prev;
	assign token_lo    = st.token[127:0];
	assign token_short = st.token[chc_pkg::CHC_SHORT_HI:chc_pkg::CHC_SHORT_LO];

	assign host_active = eng.cmd_line_busy | eng.dat_xfer_busy |
		eng.dat_engaged;
	assign card_busy_dat0 = eng.r1b_watch & ~dat0_s;

	always_comb begin
		host_cond = 16'h0000;
		host_cond[chc_pkg::CHC_HC_HOST_ACTIVE] = host_active;
		host_cond[chc_pkg::CHC_HC_CMD_ACTIVE]  = eng.cmd_line_busy;
		host_cond[chc_pkg::CHC_HC_DAT_ACTIVE]  = eng.dat_xfer_busy;
		host_cond[chc_pkg::CHC_HC_BUSY_DAT0]   = card_busy_dat0;
		host_cond[chc_pkg::CHC_HC_WRITE_PROT]  = wp_s;
	end

	assign rd_cmd_ev    = reg_rd && addr8 == chc_pkg::CHC_ADDR_CMD_EVENT;
	assign rd_xfer_ev   = reg_rd && addr8 == chc_pkg::CHC_ADDR_XFER_EVENT;
	assign rd_card_cond = reg_rd && addr8 == chc_pkg::CHC_ADDR_CARD_COND;

	// card status loads after R1 and R1b replies
	assign card_load_en = eng.resp_store &&
		(eng.reply_kind == chc_pkg::CHC_REPLY_R1 ||
		eng.reply_kind == chc_pkg::CHC_REPLY_R1B);
	// only defined error bits can be 1
	assign card_load = card_load_en ?
		(token_short & chc_pkg::CHC_CARD_COND_VALID) : 32'h0000_0000;

	always_comb begin
		next_st = st;
		next_st.sclk_prev = sclk_s;

		// reply token shifts in MSB first on each card clock rise while resp_window is set
		if (eng.resp_window && sclk_rise) begin
			next_st.token = {st.token[chc_pkg::CHC_TOKEN_BITS-2:0], cmd_s};
		end

		// words change only when a new reply is stored
		if (eng.resp_store && eng.reply_kind != chc_pkg::CHC_REPLY_NONE) begin
			if (eng.reply_kind == chc_pkg::CHC_REPLY_R2) begin
				// long reply fills all four words
				next_st.reply = token_lo;
			end else begin
				// short reply fills word 0 only
				next_st.reply[31:0] = token_short;
			end
		end

		next_st.cmd_event = (rd_cmd_ev ? 4'h0 : st.cmd_event) | eng.cmd_ev;
		next_st.xfer_event = (rd_xfer_ev ? 3'h0 : st.xfer_event) |
			eng.xfer_ev;
		next_st.card_cond = (rd_card_cond ? 32'h0000_0000 : st.card_cond) |
			card_load;

		if (reg_wr) begin
			case (addr8)
				chc_pkg::CHC_ADDR_CMD_PARAM: begin
					next_st.cmd_param = reg_wdata;
				end
				chc_pkg::CHC_ADDR_SUPPRESS_0: begin
					next_st.suppress[31:0] = reg_wdata;
				end
				chc_pkg::CHC_ADDR_SUPPRESS_1: begin
					next_st.suppress[63:32] = reg_wdata;
				end
				default: begin
				end
			endcase
		end

		// read data stands only in the cycle after the strobe
		next_st.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (addr8)
				chc_pkg::CHC_ADDR_CMD_PARAM: begin
					next_st.rdata = st.cmd_param;
				end
				chc_pkg::CHC_ADDR_HOST_COND: begin
					next_st.rdata = {16'h0000, host_cond};
				end
				chc_pkg::CHC_ADDR_REPLY_0: begin
					next_st.rdata = st.reply[31:0];
				end
				chc_pkg::CHC_ADDR_REPLY_1: begin
					next_st.rdata = st.reply[63:32];
				end
				chc_pkg::CHC_ADDR_REPLY_2: begin
					next_st.rdata = st.reply[95:64];
				end
				chc_pkg::CHC_ADDR_REPLY_3: begin
					next_st.rdata = st.reply[127:96];
				end
				chc_pkg::CHC_ADDR_CMD_EVENT: begin
					next_st.rdata = {28'h0000000, st.cmd_event};
				end
				chc_pkg::CHC_ADDR_XFER_EVENT: begin
					next_st.rdata = {29'h0000000, st.xfer_event};
				end
				chc_pkg::CHC_ADDR_CARD_COND: begin
					next_st.rdata = st.card_cond;
				end
				chc_pkg::CHC_ADDR_SUPPRESS_0: begin
					next_st.rdata = st.suppress[31:0];
				end
				chc_pkg::CHC_ADDR_SUPPRESS_1: begin
					next_st.rdata = st.suppress[63:32];
				end
				default: begin
					next_st.rdata = 32'h0000_0000;
				end
			endcase
		end

		// a mask 1 suppresses its source
		next_st.irq =
			(|({12'h000, next_st.cmd_event} & ~next_st.suppress[15:0])) |
			(|({13'h0000, next_st.xfer_event} & ~next_st.suppress[31:16])) |
			(|(next_st.card_cond & ~next_st.suppress[63:32]));
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st <= chc_pkg::CHC_STATE_RST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign card_irq  = st.irq;

	property p_arg_write;
		@(posedge sys_clk) disable iff (!rstn)
		(ce && reg_wr && addr8 == chc_pkg::CHC_ADDR_CMD_PARAM)
		|=> (st.cmd_param == $past(reg_wdata));
	endproperty
	a_arg_write: assert property (p_arg_write)
		else $error("argument register did not take the write");

	property p_host_idle;
		@(posedge sys_clk) disable iff (!rstn)
		(ce && reg_rd && addr8 == chc_pkg::CHC_ADDR_HOST_COND &&
		!eng.cmd_line_busy && !eng.dat_xfer_busy && !eng.dat_engaged)
		|=> !reg_rdata[chc_pkg::CHC_HC_HOST_ACTIVE];
	endproperty
	a_host_idle: assert property (p_host_idle)
		else $error("host_active read 1 while idle");

	property p_cmd_active;
		@(posedge sys_clk) disable iff (!rstn)
		(ce && reg_rd && addr8 == chc_pkg::CHC_ADDR_HOST_COND &&
		eng.cmd_line_busy)
		|=> (reg_rdata[chc_pkg::CHC_HC_CMD_ACTIVE] &&
		reg_rdata[chc_pkg::CHC_HC_HOST_ACTIVE]);
	endproperty
	a_cmd_active: assert property (p_cmd_active)
		else $error("command line activity not shown");

	property p_busy_dat0;
		@(posedge sys_clk) disable iff (!rstn)
		(ce && reg_rd && addr8 == chc_pkg::CHC_ADDR_HOST_COND &&
		eng.r1b_watch && !dat0_s)
		|=> reg_rdata[chc_pkg::CHC_HC_BUSY_DAT0];
	endproperty
	a_busy_dat0: assert property (p_busy_dat0)
		else $error("card busy on DAT0 not shown");

	property p_long_reply;
		@(posedge sys_clk) disable iff (!rstn)
		(ce && eng.resp_store && eng.reply_kind == chc_pkg::CHC_REPLY_R2)
		|=> (st.reply == $past(token_lo));
	endproperty
	a_long_reply: assert property (p_long_reply)
		else $error("long reply not stored in four words");

	property p_read_clear;
		@(posedge sys_clk) disable iff (!rstn)
		(ce && rd_cmd_ev && eng.cmd_ev == 4'h0)
		|=> (st.cmd_event == 4'h0);
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("command event register not cleared by read");

	property p_done_sticky;
		@(posedge sys_clk) disable iff (!rstn)
		(ce && eng.cmd_ev[chc_pkg::CHC_CE_CMD_DONE])
		|=> st.cmd_event[chc_pkg::CHC_CE_CMD_DONE];
	endproperty
	a_done_sticky: assert property (p_done_sticky)
		else $error("cmd_done event lost");

	property p_card_load;
		@(posedge sys_clk) disable iff (!rstn)
		(ce && card_load_en)
		|=> (((st.card_cond & $past(card_load)) == $past(card_load)) &&
		((st.card_cond & ~chc_pkg::CHC_CARD_COND_VALID) == 32'h0000_0000));
	endproperty
	a_card_load: assert property (p_card_load)
		else $error("card status not loaded after R1 reply");

	property p_irq_hold;
		@(posedge sys_clk) disable iff (!rstn)
		(ce && st.cmd_event[chc_pkg::CHC_CE_CMD_DONE] &&
		!st.suppress[chc_pkg::CHC_CE_CMD_DONE] && !rd_cmd_ev && !reg_wr)
		|=> card_irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("interrupt dropped while unmasked event set");

	property p_dat_active;
		@(posedge sys_clk) disable iff (!rstn)
		(ce && reg_rd && addr8 == chc_pkg::CHC_ADDR_HOST_COND &&
		eng.dat_xfer_busy)
		|=> (reg_rdata[chc_pkg::CHC_HC_DAT_ACTIVE] &&
		reg_rdata[chc_pkg::CHC_HC_HOST_ACTIVE]);
	endproperty
	a_dat_active: assert property (p_dat_active)
		else $error("data line activity not shown");

	property p_wp_show;
		@(posedge sys_clk) disable iff (!rstn)
		(ce && reg_rd && addr8 == chc_pkg::CHC_ADDR_HOST_COND)
		|=> (reg_rdata[chc_pkg::CHC_HC_WRITE_PROT] == $past(wp_s));
	endproperty
	a_wp_show: assert property (p_wp_show)
		else $error("write-protect level not shown");

	property p_reply_keep;
		@(posedge sys_clk) disable iff (!rstn)
		!(eng.resp_store && eng.reply_kind != chc_pkg::CHC_REPLY_NONE)
		|=> $stable(st.reply);
	endproperty
	a_reply_keep: assert property (p_reply_keep)
		else $error("reply words changed without a new reply");

	property p_block_sticky;
		@(posedge sys_clk) disable iff (!rstn)
		(ce && eng.xfer_ev[chc_pkg::CHC_XE_BLOCK_DONE])
		|=> st.xfer_event[chc_pkg::CHC_XE_BLOCK_DONE];
	endproperty
	a_block_sticky: assert property (p_block_sticky)
		else $error("block_finished event lost");
endmodule
`default_nettype wire

// file: chc_status_regs_test.sv
// self-checking bench for the card host status register block
// assumes chc_pkg, the block and chc_card_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module chc_status_regs_test;
	logic              sys_clk;
	logic              rstn;
	logic [7:0]        reg_addr;
	logic [31:0]       reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic              ce;
	logic [31:0]       reg_rdata;
	logic              card_sclk;
	logic              card_cmd;
	logic              card_dat0;
	logic              card_wp;
	chc_pkg::chc_eng_s eng;
	logic              card_irq;
	logic              busy;
	logic              wp;
	logic [31:0]       rd_val;
	int                n_errors;
	int                checks_done;
	int                cyc;

	chc_status_regs dut (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.ce        (ce),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.card_sclk (card_sclk),
		.card_cmd  (card_cmd),
		.card_dat0 (card_dat0),
		.card_wp   (card_wp),
		.eng       (eng),
		.card_irq  (card_irq)
	);

	chc_card_model card (
		.busy      (busy),
		.wp        (wp),
		.card_sclk (card_sclk),
		.card_cmd  (card_cmd),
		.card_dat0 (card_dat0),
		.card_wp   (card_wp)
	);

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic irqc(input logic e);
		chk({31'h0, card_irq}, {31'h0, e});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
		chk(rd_val, e);
	endtask

	task automatic ev(input logic [3:0] c, input logic [2:0] x);
		@(posedge sys_clk);
		eng.cmd_ev  <= c;
		eng.xfer_ev <= x;
		@(posedge sys_clk);
		eng.cmd_ev  <= 4'h0;
		eng.xfer_ev <= 3'h0;
		#1;
	endtask

	task automatic hc(input logic [3:0] lv, input logic b, input logic w,
			input logic [31:0] e);
		@(posedge sys_clk);
		{eng.cmd_line_busy, eng.dat_xfer_busy, eng.dat_engaged,
			eng.r1b_watch} <= lv;
		busy <= b;
		wp   <= w;
		repeat (4) @(posedge sys_clk);
		rdc(8'h2C, e);
	endtask

	task automatic reply(input logic [2:0] k, input logic [135:0] v,
			input int n);
		@(posedge sys_clk);
		eng.resp_window <= 1'b1;
		card.send(v, n);
		repeat (5) @(posedge sys_clk);
		eng.reply_kind <= k;
		eng.resp_store <= 1'b1;
		@(posedge sys_clk);
		eng.resp_store  <= 1'b0;
		eng.resp_window <= 1'b0;
		#1;
	endtask

	task automatic t_reset;
		for (int a = 8'h28; a <= 8'h50; a += 4)
			rdc(8'(a), 32'h0); // all clear after reset
		rdc(8'h00, 32'h0);
		wr(8'h28, 32'hA5A5_5A5A);
		wr(8'h30, 32'hFFFF_FFFF);
		rdc(8'h28, 32'hA5A5_5A5A); // argument readback
		rdc(8'h30, 32'h0); // read-only word
		$display("test reset_map done");
	endtask

	task automatic t_status;
		hc(4'b1000, 1'b0, 1'b0, 32'h0003); // cmd line
		hc(4'b0100, 1'b0, 1'b0, 32'h0005); // data lines
		hc(4'b0010, 1'b0, 1'b0, 32'h0001); // erase occupancy
		hc(4'b0011, 1'b1, 1'b0, 32'h0011); // dat0 busy
		hc(4'b0011, 1'b0, 1'b0, 32'h0001); // dat0 released
		hc(4'b0000, 1'b0, 1'b1, 32'h8000); // protected
		hc(4'b0000, 1'b0, 1'b0, 32'h0000); // idle
		$display("test status done");
	endtask

	task automatic t_events;
		for (int i = 0; i < 4; i++) begin
			ev(4'(1 << i), 3'h0);
			irqc(1'b1); // command source
			rdc(8'h40, 32'(1 << i)); // each bit
			irqc(1'b0); // read deasserts
			rdc(8'h40, 32'h0); // cleared
		end
		for (int i = 0; i < 3; i++) begin
			ev(4'h0, 3'(1 << i));
			irqc(1'b1); // transfer source
			rdc(8'h44, 32'(1 << i)); // each bit
			irqc(1'b0); // drops after read
		end
		wr(8'h4C, 32'h0001_0001);
		ev(4'h1, 3'h1);
		irqc(1'b0); // masked sources
		ev(4'h2, 3'h0);
		irqc(1'b1); // unmasked source
		rdc(8'h40, 32'h3); // masked bit still recorded
		rdc(8'h44, 32'h1); // masked bit still recorded
		wr(8'h4C, 32'h0);
		@(posedge sys_clk);
		ce <= 1'b0;
		ev(4'h1, 3'h1);
		irqc(1'b0); // nothing taken while frozen
		@(posedge sys_clk);
		ce <= 1'b1;
		rdc(8'h40, 32'h0); // pulse while frozen not recorded
		rdc(8'h44, 32'h0); // pulse while frozen not recorded
		$display("test events done");
	endtask

	task automatic t_reply;
		reply(3'b010, {8'h3F, 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210},
			136);
		rdc(8'h30, 32'h7654_3210); // word 0
		rdc(8'h34, 32'hFEDC_BA98); // word 1
		rdc(8'h38, 32'h89AB_CDEF); // word 2
		rdc(8'h3C, 32'h0123_4567); // word 3
		rdc(8'h48, 32'h0); // long reply leaves status
		reply(3'b001, {88'h0, 8'h05, 32'hA5C3_0F18, 8'hFF}, 48);
		irqc(1'b1); // card status source
		rdc(8'h30, 32'hA5C3_0F18); // short reply bits
		rdc(8'h34, 32'hFEDC_BA98); // upper words kept
		wr(8'h50, 32'hFFFF_FFFF);
		@(posedge sys_clk);
		#1 irqc(1'b0); // upper mask
		rdc(8'h48, 32'hA5C3_0008); // error bits
		rdc(8'h48, 32'h0); // cleared by read
		wr(8'h50, 32'h0);
		reply(3'b111, {88'h0, 8'h0D, 32'h8000_0001, 8'hFF}, 48);
		rdc(8'h48, 32'h8000_0000); // busy-kind status
		reply(3'b000, {88'h0, 8'h05, 32'h1111_1111, 8'hFF}, 48);
		rdc(8'h30, 32'h8000_0001); // no-reply kind keeps words
		reply(3'b110, {88'h0, 8'h05, 32'h5A5A_0008, 8'hFF}, 48);
		irqc(1'b0); // other kinds raise no status
		rdc(8'h30, 32'h5A5A_0008); // other kinds fill word 0
		rdc(8'h48, 32'h0); // no card status for other kinds
		$display("test replies done");
	endtask

	initial begin
		rstn      = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 32'h0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		ce        = 1'b1;
		eng       = '0;
		busy      = 1'b0;
		wp        = 1'b0;
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_status();
		t_events();
		t_reply();
		summarize();
	end
endmodule
`default_nettype wire

// file: chc_sync.sv
// two-stage synchroniser for a group of asynchronous inputs
// assumes the inputs come from pins or another clock domain
`timescale 1ns/10ps
`default_nettype none
module chc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} chc_sync_s;

	chc_sync_s st;
	chc_sync_s next_st;

	always_comb begin
		next_st        = st;
		next_st.first  = din;
		next_st.second = st.first;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign dout = st.second;
endmodule
`default_nettype wire
